// *** rtl/cab_alu8.sv ***
`timescale 1ns/1ps
`default_nettype none
module cab_alu8 (
  // Adder port
  cab_dp_if.alu bus
);
  logic [7:0] opb;
  logic cin_eff;
  logic [8:0] sum;
  logic [4:0] low;

  // Subtract as add of inverted operand, carry becomes borrow
  assign opb = bus.alu_sub ? ~bus.alu_b : bus.alu_b;
  assign cin_eff = bus.alu_sub ? ~bus.alu_cin : bus.alu_cin;
  assign sum = {1'b0, bus.alu_a} + {1'b0, opb} + {8'h00, cin_eff};
  assign low = {1'b0, bus.alu_a[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin_eff};
  assign bus.alu_r = sum[7:0];
  assign bus.alu_c = bus.alu_sub ? ~sum[8] : sum[8];
  assign bus.alu_h = bus.alu_sub ? ~low[4] : low[4];
  assign bus.alu_v = (bus.alu_a[7] == opb[7]) && (sum[7] != bus.alu_a[7]);
endmodule : cab_alu8
`default_nettype wire

// *** rtl/cab_datapath.sv ***
// Contract
// (RULE_01) Add registers, optional carry, five flags, one cycle
// (RULE_02) Pair plus constant, Z C N V S, two cycles
// (RULE_03) Subtract register or constant, five flags, one cycle
// (RULE_04) Subtract with borrow, register or constant, one cycle
// (RULE_05) Pair minus constant, Z C N V S, two cycles
// (RULE_06) AND register or constant, Z N V, one cycle
// (RULE_07) OR reg/const, XOR regs, Z N V, one cycle
// (RULE_08) Set bits ORs mask, Z N V, one cycle
// (RULE_09) Clear bits ANDs inverted mask, one cycle
// (RULE_10) Test ANDs register with itself, Z N V
// (RULE_11) Integer multiply into R1:R0, Z C, two cycles
// (RULE_12) Fractional multiply shifted left one, two cycles
// (RULE_13) Relative jump two, call three, PC+k+1
// (RULE_14) Pointer jump two cycles, absolute jump three
// (RULE_15) Ones and twos complement, one cycle
// (RULE_16) Increment, decrement, clear, set register, one cycle
`timescale 1ns/1ps
`default_nettype none
module cab_datapath #(
  parameter int PC_W = cab_pkg::PC_W_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Operation request
  input wire logic op_valid,
  input wire logic [5:0] op_code,
  input wire logic [7:0] dst_val,
  input wire logic [7:0] src_reg,
  input wire logic [7:0] imm_val,
  input wire logic [15:0] pair_val,
  input wire logic [PC_W-1:0] pc_val,
  input wire logic [PC_W-1:0] z_ptr,
  input wire logic [PC_W-1:0] abs_addr,
  input wire logic [11:0] rel_offset,
  // Results
  output logic busy,
  output logic done,
  output logic dst_we,
  output logic [7:0] dst_data,
  output logic pair_we,
  output logic prod_we,
  output logic [15:0] word_data,
  output logic pc_we,
  output logic [PC_W-1:0] pc_data,
  output logic ret_push,
  output logic [PC_W-1:0] ret_addr,
  output logic [7:0] sreg
);
  typedef enum logic {ST_IDLE, ST_WAIT} cab_st_t;
  typedef struct packed {
    cab_st_t st;
    logic [1:0] cnt;
    logic busy;
    logic done;
    logic dst_we;
    logic pair_we;
    logic prod_we;
    logic pc_we;
    logic push;
    logic a_dst;
    logic a_pair;
    logic a_prod;
    logic a_pc;
    logic a_push;
    logic [7:0] dst;
    logic [15:0] word;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] ret;
    logic [7:0] fp;
    logic [7:0] sreg;
  } cab_state_t;

  cab_state_t q;
  cab_state_t next_q;
  cab_pkg::cab_op_t op_sel;
  logic acc;
  logic [PC_W-1:0] rel_sum;

  if (PC_W < cab_pkg::PC_W_MIN) begin : g_chk
    $error("PC_W too narrow for the relative offset");
  end

  cab_dp_if dp();
  cab_alu8 u_alu (.bus(dp.alu));
  cab_mul8 u_mul (.bus(dp.mul));

  ////////////////////////////////////////////////////////////////////////////
  // Operand steering
  assign op_sel = cab_pkg::cab_op_t'(op_code);
  assign acc = op_valid && (q.st == ST_IDLE);
  assign rel_sum = pc_val + PC_W'($signed(rel_offset)) + PC_W'(1);
  assign dp.alu_sub = op_sel inside {cab_pkg::OP_REG_DIFF, cab_pkg::OP_CONST_DIFFERENCE,
    cab_pkg::OP_REG_DIFF_BORROW, cab_pkg::OP_CONST_DIFF_BORROW, cab_pkg::OP_TWOS_COMPLEMENT,
    cab_pkg::OP_MINUS_ONE};
  assign dp.alu_a = (op_sel == cab_pkg::OP_TWOS_COMPLEMENT) ? cab_pkg::ZERO_8 : dst_val;
  assign dp.alu_b = (op_sel == cab_pkg::OP_TWOS_COMPLEMENT) ? dst_val :
    (op_sel inside {cab_pkg::OP_PLUS_ONE, cab_pkg::OP_MINUS_ONE}) ? cab_pkg::ONE_8 :
    (op_sel inside {cab_pkg::OP_CONST_DIFFERENCE, cab_pkg::OP_CONST_DIFF_BORROW}) ? imm_val :
    src_reg;
  assign dp.alu_cin = (op_sel inside {cab_pkg::OP_ADD_CARRY, cab_pkg::OP_REG_DIFF_BORROW,
    cab_pkg::OP_CONST_DIFF_BORROW}) && q.sreg[cab_pkg::FLG_C];
  assign dp.mul_a = dst_val;
  assign dp.mul_b = src_reg;
  assign dp.mul_sa = op_sel inside {cab_pkg::OP_PRODUCT_SIGNED, cab_pkg::OP_PRODUCT_MIXED,
    cab_pkg::OP_FRAC_PRODUCT_SIGNED, cab_pkg::OP_FRAC_PRODUCT_MIXED};
  assign dp.mul_sb = op_sel inside {cab_pkg::OP_PRODUCT_SIGNED, cab_pkg::OP_FRAC_PRODUCT_SIGNED};
  assign dp.mul_frac = op_sel inside {cab_pkg::OP_FRAC_PRODUCT_UNSIGNED,
    cab_pkg::OP_FRAC_PRODUCT_SIGNED, cab_pkg::OP_FRAC_PRODUCT_MIXED};

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [7:0] f;
    logic [7:0] lr;
    logic [16:0] ws;
    logic [1:0] cyc;
    logic zn;
    f = q.sreg;
    lr = dst_val;
    ws = '0;
    cyc = cab_pkg::CYC_ONE;
    zn = 1'b0;
    next_q = q;
    next_q.done = 1'b0;
    next_q.dst_we = 1'b0;
    next_q.pair_we = 1'b0;
    next_q.prod_we = 1'b0;
    next_q.pc_we = 1'b0;
    next_q.push = 1'b0;
    case (q.st)
      ST_IDLE: begin
        if (op_valid) begin
          next_q.a_dst = 1'b1;
          next_q.a_pair = 1'b0;
          next_q.a_prod = 1'b0;
          next_q.a_pc = 1'b0;
          next_q.a_push = 1'b0;
          next_q.ret = pc_val + PC_W'(1);
          case (op_sel)
            cab_pkg::OP_ADD, cab_pkg::OP_ADD_CARRY, cab_pkg::OP_REG_DIFF,
            cab_pkg::OP_CONST_DIFFERENCE, cab_pkg::OP_REG_DIFF_BORROW,
            cab_pkg::OP_CONST_DIFF_BORROW, cab_pkg::OP_TWOS_COMPLEMENT: begin
              lr = dp.alu_r; // [RULE_01] [RULE_03] [RULE_04] [RULE_15]
              f[cab_pkg::FLG_C] = dp.alu_c;
              f[cab_pkg::FLG_H] = dp.alu_h;
              f[cab_pkg::FLG_V] = dp.alu_v;
              zn = 1'b1;
            end
            cab_pkg::OP_PLUS_ONE, cab_pkg::OP_MINUS_ONE: begin
              lr = dp.alu_r; // [RULE_16]
              f[cab_pkg::FLG_V] = dp.alu_v;
              zn = 1'b1;
            end
            cab_pkg::OP_PAIR_PLUS_CONST, cab_pkg::OP_PAIR_MINUS_CONST: begin
              next_q.a_dst = 1'b0;
              next_q.a_pair = 1'b1;
              if (op_sel == cab_pkg::OP_PAIR_PLUS_CONST) begin
                ws = {1'b0, pair_val} + {11'h000, imm_val[cab_pkg::KW_W-1:0]}; // [RULE_02]
                f[cab_pkg::FLG_V] = ~pair_val[15] & ws[15];
                f[cab_pkg::FLG_C] = pair_val[15] & ~ws[15];
              end else begin
                ws = {1'b0, pair_val} - {11'h000, imm_val[cab_pkg::KW_W-1:0]}; // [RULE_05]
                f[cab_pkg::FLG_V] = pair_val[15] & ~ws[15];
                f[cab_pkg::FLG_C] = ~pair_val[15] & ws[15];
              end
              next_q.word = ws[15:0];
              f[cab_pkg::FLG_Z] = (ws[15:0] == 16'h0000);
              f[cab_pkg::FLG_N] = ws[15];
              f[cab_pkg::FLG_S] = ws[15] ^ f[cab_pkg::FLG_V];
            end
            cab_pkg::OP_AND_REGS: begin
              lr = dst_val & src_reg; // [RULE_06]
              zn = 1'b1;
            end
            cab_pkg::OP_MASK_AND_CONST: begin
              lr = dst_val & imm_val; // [RULE_06]
              zn = 1'b1;
            end
            cab_pkg::OP_OR_REGS: begin
              lr = dst_val | src_reg; // [RULE_07]
              zn = 1'b1;
            end
            cab_pkg::OP_MASK_OR_CONST, cab_pkg::OP_SET_BITS: begin
              lr = dst_val | imm_val; // [RULE_07] [RULE_08]
              zn = 1'b1;
            end
            cab_pkg::OP_EXCLUSIVE_OR_REGS: begin
              lr = dst_val ^ src_reg; // [RULE_07]
              zn = 1'b1;
            end
            cab_pkg::OP_CLEAR_BITS: begin
              lr = dst_val & (cab_pkg::ALL_ONES - imm_val); // [RULE_09]
              zn = 1'b1;
            end
            cab_pkg::OP_ZERO_SIGN_TEST: begin
              lr = dst_val & dst_val; // [RULE_10]
              zn = 1'b1;
            end
            cab_pkg::OP_ONES_COMPLEMENT: begin
              lr = cab_pkg::ALL_ONES - dst_val; // [RULE_15]
              f[cab_pkg::FLG_C] = 1'b1;
              zn = 1'b1;
            end
            cab_pkg::OP_ZERO_REGISTER: begin
              lr = dst_val ^ dst_val; // [RULE_16]
              zn = 1'b1;
            end
            cab_pkg::OP_ONES_REGISTER: begin
              lr = cab_pkg::ALL_ONES; // [RULE_16]
            end
            cab_pkg::OP_PRODUCT_UNSIGNED, cab_pkg::OP_PRODUCT_SIGNED, cab_pkg::OP_PRODUCT_MIXED,
            cab_pkg::OP_FRAC_PRODUCT_UNSIGNED, cab_pkg::OP_FRAC_PRODUCT_SIGNED,
            cab_pkg::OP_FRAC_PRODUCT_MIXED: begin
              next_q.a_dst = 1'b0;
              next_q.a_prod = 1'b1;
              next_q.word = dp.mul_r; // [RULE_11] [RULE_12]
              f[cab_pkg::FLG_C] = dp.mul_c;
              f[cab_pkg::FLG_Z] = (dp.mul_r == 16'h0000);
            end
            cab_pkg::OP_RELATIVE_JUMP, cab_pkg::OP_RELATIVE_CALL: begin
              next_q.a_dst = 1'b0;
              next_q.a_pc = 1'b1;
              next_q.a_push = (op_sel == cab_pkg::OP_RELATIVE_CALL);
              next_q.pc = rel_sum; // [RULE_13]
            end
            cab_pkg::OP_POINTER_JUMP, cab_pkg::OP_ABSOLUTE_JUMP: begin
              next_q.a_dst = 1'b0;
              next_q.a_pc = 1'b1;
              next_q.pc = (op_sel == cab_pkg::OP_POINTER_JUMP) ? z_ptr : abs_addr; // [RULE_14]
            end
            default: begin
              next_q.a_dst = 1'b0;
            end
          endcase
          if (zn) begin
            f[cab_pkg::FLG_Z] = (lr == cab_pkg::ZERO_8);
            f[cab_pkg::FLG_N] = lr[7];
            if (!(op_sel inside {cab_pkg::OP_ADD, cab_pkg::OP_ADD_CARRY, cab_pkg::OP_REG_DIFF,
                cab_pkg::OP_CONST_DIFFERENCE, cab_pkg::OP_REG_DIFF_BORROW,
                cab_pkg::OP_CONST_DIFF_BORROW, cab_pkg::OP_TWOS_COMPLEMENT,
                cab_pkg::OP_PLUS_ONE, cab_pkg::OP_MINUS_ONE})) begin
              f[cab_pkg::FLG_V] = 1'b0; // [RULE_06] [RULE_07]
            end
          end
          // Borrow chain keeps zero only if previous result was zero
          if (op_sel inside {cab_pkg::OP_REG_DIFF_BORROW, cab_pkg::OP_CONST_DIFF_BORROW}) begin
            f[cab_pkg::FLG_Z] = f[cab_pkg::FLG_Z] & q.sreg[cab_pkg::FLG_Z]; // [RULE_04]
          end
          next_q.dst = lr;
          cyc = cab_pkg::cab_cycles(op_sel);
          if (cyc == cab_pkg::CYC_ONE) begin
            next_q.done = 1'b1;
            next_q.sreg = f;
            next_q.dst_we = next_q.a_dst;
          end else begin
            next_q.st = ST_WAIT;
            next_q.busy = 1'b1;
            next_q.cnt = cyc - cab_pkg::CYC_ONE;
            next_q.fp = f;
          end
        end
      end
      ST_WAIT: begin
        next_q.cnt = q.cnt - cab_pkg::CYC_ONE;
        if (q.cnt == cab_pkg::CYC_ONE) begin
          next_q.st = ST_IDLE;
          next_q.busy = 1'b0;
          next_q.done = 1'b1;
          next_q.sreg = q.fp;
          next_q.dst_we = q.a_dst;
          next_q.pair_we = q.a_pair;
          next_q.prod_we = q.a_prod;
          next_q.pc_we = q.a_pc;
          next_q.push = q.a_push;
        end
      end
      default: begin
        next_q.st = ST_IDLE;
        next_q.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.sreg <= cab_pkg::SREG_RST;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign busy = q.busy;
  assign done = q.done;
  assign dst_we = q.dst_we;
  assign dst_data = q.dst;
  assign pair_we = q.pair_we;
  assign prod_we = q.prod_we;
  assign word_data = q.word;
  assign pc_we = q.pc_we;
  assign pc_data = q.pc;
  assign ret_push = q.push;
  assign ret_addr = q.ret;
  assign sreg = q.sreg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  add_result_a: assert property (acc && op_sel == cab_pkg::OP_ADD |=> // [RULE_01]
    done && dst_we && dst_data == 8'($past(dst_val) + $past(src_reg)))
    else $error("add result wrong");
  pair_add_a: assert property (acc && op_sel == cab_pkg::OP_PAIR_PLUS_CONST |=> // [RULE_02]
    !done && busy ##1 done && pair_we && !dst_we &&
    word_data == 16'($past(pair_val, 2) + 16'($past(imm_val[5:0], 2))))
    else $error("pair add wrong");
  sub_const_a: assert property (acc && op_sel == cab_pkg::OP_CONST_DIFFERENCE |=> // [RULE_03]
    dst_data == 8'($past(dst_val) - $past(imm_val)) &&
    sreg[cab_pkg::FLG_C] == ($past(imm_val) > $past(dst_val)))
    else $error("subtract constant wrong");
  borrow_sub_a: assert property (acc && op_sel == cab_pkg::OP_REG_DIFF_BORROW |=> // [RULE_04]
    dst_data == 8'($past(dst_val) - $past(src_reg) - 8'($past(q.sreg[cab_pkg::FLG_C]))))
    else $error("borrow subtract wrong");
  pair_sub_a: assert property (acc && op_sel == cab_pkg::OP_PAIR_MINUS_CONST |=> // [RULE_05]
    ##1 pair_we && word_data == 16'($past(pair_val, 2) - 16'($past(imm_val[5:0], 2))))
    else $error("pair subtract wrong");
  and_flags_a: assert property (acc && op_sel == cab_pkg::OP_MASK_AND_CONST |=> // [RULE_06]
    !sreg[cab_pkg::FLG_V] && sreg[cab_pkg::FLG_C] == $past(q.sreg[cab_pkg::FLG_C]) &&
    sreg[cab_pkg::FLG_Z] == (dst_data == 8'h00))
    else $error("and flags wrong");
  xor_result_a: assert property (acc && op_sel == cab_pkg::OP_EXCLUSIVE_OR_REGS |=> // [RULE_07]
    dst_data == ($past(dst_val) ^ $past(src_reg)))
    else $error("xor result wrong");
  set_bits_a: assert property (acc && op_sel == cab_pkg::OP_SET_BITS |=> // [RULE_08]
    dst_data == ($past(dst_val) | $past(imm_val)))
    else $error("set bits wrong");
  clear_bits_a: assert property (acc && op_sel == cab_pkg::OP_CLEAR_BITS |=> // [RULE_09]
    dst_data == ($past(dst_val) & ~$past(imm_val)))
    else $error("clear bits wrong");
  test_keep_a: assert property (acc && op_sel == cab_pkg::OP_ZERO_SIGN_TEST |=> // [RULE_10]
    dst_data == $past(dst_val) && sreg[cab_pkg::FLG_N] == dst_data[7])
    else $error("test changed value");
  mul_unsigned_a: assert property (acc && op_sel == cab_pkg::OP_PRODUCT_UNSIGNED |=> // [RULE_11]
    !prod_we ##1 prod_we && word_data == {8'h00, $past(dst_val, 2)} * {8'h00, $past(src_reg, 2)})
    else $error("multiply wrong");
  frac_lsb_a: assert property (acc && dp.mul_frac |-> ##2 prod_we && !word_data[0]) // [RULE_12]
    else $error("fractional product not shifted");
  call_three_a: assert property (acc && op_sel == cab_pkg::OP_RELATIVE_CALL |=> // [RULE_13]
    (!pc_we && busy)[*2] ##1 pc_we && ret_push && pc_data == $past(rel_sum, 3))
    else $error("relative call timing wrong");
  jump_flags_a: assert property (acc && op_sel == cab_pkg::OP_POINTER_JUMP |=> // [RULE_14]
    !pc_we ##1 pc_we && pc_data == $past(z_ptr, 2) && $stable(sreg))
    else $error("pointer jump wrong");
  ones_comp_a: assert property (acc && op_sel == cab_pkg::OP_ONES_COMPLEMENT |=> // [RULE_15]
    dst_data == ~$past(dst_val) && sreg[cab_pkg::FLG_C])
    else $error("ones complement wrong");
  set_reg_a: assert property (acc && op_sel == cab_pkg::OP_ONES_REGISTER |=> // [RULE_16]
    dst_data == cab_pkg::ALL_ONES && sreg == $past(q.sreg))
    else $error("set register wrong");

  add_seen_c: cover property (acc && op_sel == cab_pkg::OP_ADD_CARRY ##1 sreg[cab_pkg::FLG_C]);
  back_to_back_c: cover property (acc ##1 acc ##1 done);
  mul_signed_c: cover property (acc && op_sel == cab_pkg::OP_PRODUCT_SIGNED ##2 prod_we);
  abs_jump_c: cover property (acc && op_sel == cab_pkg::OP_ABSOLUTE_JUMP ##3 pc_we);
endmodule : cab_datapath
`default_nettype wire

// *** rtl/cab_dp_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface cab_dp_if;
  // Adder operands and results
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic alu_cin;
  logic alu_sub;
  logic [7:0] alu_r;
  logic alu_c;
  logic alu_h;
  logic alu_v;
  // Multiplier operands and results
  logic [7:0] mul_a;
  logic [7:0] mul_b;
  logic mul_sa;
  logic mul_sb;
  logic mul_frac;
  logic [15:0] mul_r;
  logic mul_c;
  modport core (output alu_a, alu_b, alu_cin, alu_sub, mul_a, mul_b, mul_sa, mul_sb, mul_frac,
                input alu_r, alu_c, alu_h, alu_v, mul_r, mul_c);
  modport alu (input alu_a, alu_b, alu_cin, alu_sub, output alu_r, alu_c, alu_h, alu_v);
  modport mul (input mul_a, mul_b, mul_sa, mul_sb, mul_frac, output mul_r, mul_c);
endinterface : cab_dp_if
`default_nettype wire

// *** rtl/cab_mul8.sv ***
`timescale 1ns/1ps
`default_nettype none
module cab_mul8 (
  // Multiplier port
  cab_dp_if.mul bus
);
  logic signed [8:0] ea;
  logic signed [8:0] eb;
  logic signed [17:0] prod;
  logic [15:0] p16;

  // Sign extend per operand, one signed multiplier serves all forms
  assign ea = {bus.mul_sa & bus.mul_a[7], bus.mul_a};
  assign eb = {bus.mul_sb & bus.mul_b[7], bus.mul_b};
  assign prod = ea * eb;
  assign p16 = prod[15:0];
  assign bus.mul_c = p16[15];
  assign bus.mul_r = bus.mul_frac ? {p16[14:0], 1'b0} : p16;
endmodule : cab_mul8
`default_nettype wire

// *** rtl/cab_pkg.sv ***
`default_nettype none
package cab_pkg;
  // Data and address widths
  localparam int DATA_W = 8;
  localparam int WORD_W = 16;
  localparam int PC_W_DEF = 16;
  localparam int PC_W_MIN = 12;
  localparam int OFFS_W = 12;
  localparam int KW_W = 6;
  // Status flag positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  // Values
  localparam logic [7:0] SREG_RST = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] ZERO_8 = 8'h00;
  localparam logic [7:0] ONE_8 = 8'h01;
  // Cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  typedef enum logic [5:0] {
    OP_ADD, OP_ADD_CARRY, OP_PAIR_PLUS_CONST, OP_REG_DIFF, OP_CONST_DIFFERENCE,
    OP_REG_DIFF_BORROW, OP_CONST_DIFF_BORROW, OP_PAIR_MINUS_CONST, OP_AND_REGS,
    OP_MASK_AND_CONST, OP_OR_REGS, OP_MASK_OR_CONST, OP_EXCLUSIVE_OR_REGS,
    OP_ONES_COMPLEMENT, OP_TWOS_COMPLEMENT, OP_SET_BITS, OP_CLEAR_BITS,
    OP_PLUS_ONE, OP_MINUS_ONE, OP_ZERO_SIGN_TEST, OP_ZERO_REGISTER, OP_ONES_REGISTER,
    OP_PRODUCT_UNSIGNED, OP_PRODUCT_SIGNED, OP_PRODUCT_MIXED, OP_FRAC_PRODUCT_UNSIGNED,
    OP_FRAC_PRODUCT_SIGNED, OP_FRAC_PRODUCT_MIXED, OP_RELATIVE_JUMP, OP_POINTER_JUMP,
    OP_ABSOLUTE_JUMP, OP_RELATIVE_CALL
  } cab_op_t;

  function automatic logic [1:0] cab_cycles(input cab_op_t op);
    case (op)
      OP_PAIR_PLUS_CONST, OP_PAIR_MINUS_CONST, OP_PRODUCT_UNSIGNED, OP_PRODUCT_SIGNED,
      OP_PRODUCT_MIXED, OP_FRAC_PRODUCT_UNSIGNED, OP_FRAC_PRODUCT_SIGNED,
      OP_FRAC_PRODUCT_MIXED, OP_RELATIVE_JUMP, OP_POINTER_JUMP: cab_cycles = CYC_TWO;
      OP_ABSOLUTE_JUMP, OP_RELATIVE_CALL: cab_cycles = CYC_THREE;
      default: cab_cycles = CYC_ONE;
    endcase
  endfunction : cab_cycles
endpackage : cab_pkg
`default_nettype wire

// *** verification/cab_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module cab_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Write-back from datapath
  input wire logic dst_we,
  input wire logic [7:0] dst_data,
  input wire logic pc_we,
  input wire logic [15:0] pc_data,
  input wire logic ret_push,
  input wire logic [15:0] ret_addr,
  // Register file view
  output logic [7:0] rd_q,
  output logic [15:0] pc_q,
  output logic [15:0] stack_q
);
  // Destination register, program counter and stack top
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_q <= 8'h00;
      pc_q <= 16'h0000;
      stack_q <= 16'h0000;
    end else begin
      if (dst_we) rd_q <= dst_data;
      if (pc_we) pc_q <= pc_data;
      if (ret_push) stack_q <= ret_addr;
    end
  end
endmodule : cab_core_model
`default_nettype wire

// *** verification/cab_datapath_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module cab_datapath_tb;
  typedef struct packed {cab_pkg::cab_op_t op; logic [7:0] d; logic [7:0] s; logic [15:0] r; logic [7:0] f;} cab_vec_t;
  logic clk, reset, op_valid, busy, done, dst_we, pair_we, prod_we, pc_we, ret_push;
  logic [5:0] op_code;
  logic [7:0] dst_val, src_reg, imm_val, dst_data, sreg, rd_q;
  logic [11:0] rel_offset;
  logic [15:0] pair_val, pc_val, z_ptr, abs_addr, word_data, pc_data, ret_addr, pc_q, stack_q;
  int failures;
  int comparisons;
  int n;
  int nb;
  cab_vec_t arith[23] = '{
    '{cab_pkg::OP_AND_REGS, 8'hf0, 8'h3c, 16'h0030, 8'h00}, '{cab_pkg::OP_MASK_AND_CONST, 8'hf0, 8'h3c, 16'h0030, 8'h00},
    '{cab_pkg::OP_OR_REGS, 8'hf0, 8'h3c, 16'h00fc, 8'h04}, '{cab_pkg::OP_MASK_OR_CONST, 8'hf0, 8'h3c, 16'h00fc, 8'h04},
    '{cab_pkg::OP_EXCLUSIVE_OR_REGS, 8'hf0, 8'h3c, 16'h00cc, 8'h04}, '{cab_pkg::OP_SET_BITS, 8'hf0, 8'h3c, 16'h00fc, 8'h04},
    '{cab_pkg::OP_CLEAR_BITS, 8'hf0, 8'h3c, 16'h00c0, 8'h04}, '{cab_pkg::OP_ZERO_SIGN_TEST, 8'hf0, 8'h3c, 16'h00f0, 8'h04},
    '{cab_pkg::OP_ZERO_REGISTER, 8'hf0, 8'h3c, 16'h0000, 8'h02}, '{cab_pkg::OP_ONES_COMPLEMENT, 8'hf0, 8'h3c, 16'h000f, 8'h01},
    '{cab_pkg::OP_TWOS_COMPLEMENT, 8'hf0, 8'h3c, 16'h0010, 8'h01}, '{cab_pkg::OP_ONES_REGISTER, 8'hf0, 8'h3c, 16'h00ff, 8'h01},
    '{cab_pkg::OP_MINUS_ONE, 8'h80, 8'h3c, 16'h007f, 8'h09}, '{cab_pkg::OP_PLUS_ONE, 8'h7f, 8'h3c, 16'h0080, 8'h0d},
    '{cab_pkg::OP_ADD, 8'h0f, 8'h01, 16'h0010, 8'h20}, '{cab_pkg::OP_ADD_CARRY, 8'hff, 8'h01, 16'h0000, 8'h23},
    '{cab_pkg::OP_ADD_CARRY, 8'h01, 8'h01, 16'h0003, 8'h00}, '{cab_pkg::OP_REG_DIFF, 8'h00, 8'h01, 16'h00ff, 8'h25},
    '{cab_pkg::OP_CONST_DIFF_BORROW, 8'h05, 8'h02, 16'h0002, 8'h00}, '{cab_pkg::OP_CONST_DIFFERENCE, 8'h80, 8'h01, 16'h007f, 8'h28},
    '{cab_pkg::OP_REG_DIFF_BORROW, 8'h10, 8'h10, 16'h0000, 8'h00}, '{cab_pkg::OP_REG_DIFF, 8'h10, 8'h10, 16'h0000, 8'h02},
    '{cab_pkg::OP_REG_DIFF_BORROW, 8'h20, 8'h20, 16'h0000, 8'h02}};
  cab_vec_t mul[7] = '{
    '{cab_pkg::OP_PRODUCT_UNSIGNED, 8'hff, 8'hff, 16'hfe01, 8'h15}, '{cab_pkg::OP_PRODUCT_SIGNED, 8'hff, 8'hff, 16'h0001, 8'h14},
    '{cab_pkg::OP_PRODUCT_MIXED, 8'hff, 8'h02, 16'hfffe, 8'h15}, '{cab_pkg::OP_FRAC_PRODUCT_UNSIGNED, 8'h80, 8'h80, 16'h8000, 8'h14},
    '{cab_pkg::OP_FRAC_PRODUCT_SIGNED, 8'h80, 8'h80, 16'h8000, 8'h14}, '{cab_pkg::OP_FRAC_PRODUCT_MIXED, 8'h80, 8'h40, 16'hc000, 8'h15},
    '{cab_pkg::OP_PRODUCT_UNSIGNED, 8'h00, 8'h55, 16'h0000, 8'h16}};

  cab_datapath #(.PC_W(16)) cab_datapath_inst (.clk(clk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
    .dst_val(dst_val), .src_reg(src_reg), .imm_val(imm_val), .pair_val(pair_val), .pc_val(pc_val), .z_ptr(z_ptr),
    .abs_addr(abs_addr), .rel_offset(rel_offset), .busy(busy), .done(done), .dst_we(dst_we), .dst_data(dst_data),
    .pair_we(pair_we), .prod_we(prod_we), .word_data(word_data), .pc_we(pc_we), .pc_data(pc_data),
    .ret_push(ret_push), .ret_addr(ret_addr), .sreg(sreg));
  cab_core_model cab_core_model_inst (.clk(clk), .reset(reset), .dst_we(dst_we), .dst_data(dst_data),
    .pc_we(pc_we), .pc_data(pc_data), .ret_push(ret_push), .ret_addr(ret_addr), .rd_q(rd_q), .pc_q(pc_q),
    .stack_q(stack_q));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic chk_out(input logic [15:0] r, input logic [15:0] seen, input logic we, input logic [7:0] f,
                         input int c);
    check("result", seen, r);
    check("write strobe", {15'h0000, we}, 16'h0001);
    check("flags", {8'h00, sreg}, {8'h00, f});
    check("cycles", 16'(n), 16'(c));
    check("busy cycles", 16'(nb), 16'(c - 1));
  endtask : chk_out

  task automatic wait_done();
    n = 0;
    nb = 0;
    // Sample mid-cycle, while the one-cycle done pulse stands
    do begin
      @(negedge clk);
      n++;
      if (busy === 1'b1) begin
        nb++;
      end
    end while (done !== 1'b1 && n < 8);
    if (done !== 1'b1) begin
      check("done timeout", {15'h0000, done}, 16'h0001);
      finish_test();
    end
  endtask : wait_done

  task automatic run(input cab_pkg::cab_op_t op, input logic [7:0] d, input logic [7:0] s,
                     input logic [15:0] pw, input logic [15:0] pc, input logic [11:0] k);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= op;
    dst_val <= d;
    src_reg <= s;
    imm_val <= s;
    pair_val <= pw;
    pc_val <= pc;
    rel_offset <= k;
    @(posedge clk);
    op_valid <= 1'b0;
    wait_done();
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  task automatic s_arith();
    foreach (arith[i]) begin
      run(arith[i].op, arith[i].d, arith[i].s, 16'h0000, 16'h0000, 12'h000);
      chk_out(arith[i].r, {8'h00, dst_data}, dst_we, arith[i].f, 1);
    end
  endtask : s_arith

  task automatic s_word();
    run(cab_pkg::OP_PAIR_PLUS_CONST, 8'h00, 8'h01, 16'h7fff, 16'h0000, 12'h000);
    chk_out(16'h8000, word_data, pair_we, 8'h0c, 2);
    run(cab_pkg::OP_PAIR_MINUS_CONST, 8'h00, 8'hff, 16'h0000, 16'h0000, 12'h000);
    chk_out(16'hffc1, word_data, pair_we, 8'h15, 2);
  endtask : s_word

  task automatic s_mul();
    foreach (mul[i]) begin
      run(mul[i].op, mul[i].d, mul[i].s, 16'h0000, 16'h0000, 12'h000);
      chk_out(mul[i].r, word_data, prod_we, mul[i].f, 2);
    end
  endtask : s_mul

  task automatic s_branch();
    run(cab_pkg::OP_RELATIVE_JUMP, 8'h00, 8'h00, 16'h0000, 16'h0100, 12'hffe);
    chk_out(16'h00ff, pc_data, pc_we, 8'h16, 2);
    run(cab_pkg::OP_POINTER_JUMP, 8'h00, 8'h00, 16'h0000, 16'h0100, 12'h000);
    chk_out(16'h1234, pc_data, pc_we, 8'h16, 2);
    run(cab_pkg::OP_ABSOLUTE_JUMP, 8'h00, 8'h00, 16'h0000, 16'h0100, 12'h000);
    chk_out(16'hbeef, pc_data, pc_we, 8'h16, 3);
  endtask : s_branch

  task automatic s_refuse();
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= cab_pkg::OP_RELATIVE_CALL;
    pc_val <= 16'h0200;
    rel_offset <= 12'h7ff;
    @(posedge clk);
    op_code <= cab_pkg::OP_ADD;
    dst_val <= 8'h0f;
    src_reg <= 8'h01;
    wait_done();
    chk_out(16'h0a00, pc_data, pc_we, 8'h16, 3);
    check("call return", {ret_push, dst_we, ret_addr[13:0]}, {2'b10, 14'h0201});
    @(posedge clk);
    op_valid <= 1'b0;
    wait_done();
    chk_out(16'h0010, {8'h00, dst_data}, dst_we, 8'h30, 1);
    check("stack top", stack_q, 16'h0201);
    check("model pc", pc_q, 16'h0a00);
    @(negedge clk);
    check("model register", {8'h00, rd_q}, 16'h0010);
  endtask : s_refuse

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    failures = 0;
    comparisons = 0;
    reset = 1'b1;
    op_valid = 1'b0;
    op_code = 6'h00;
    dst_val = 8'h00;
    src_reg = 8'h00;
    imm_val = 8'h00;
    pair_val = 16'h0000;
    pc_val = 16'h0000;
    z_ptr = 16'h1234;
    abs_addr = 16'hbeef;
    rel_offset = 12'h000;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    s_arith();
    s_word();
    s_mul();
    s_branch();
    s_refuse();
    finish_test();
  end
endmodule : cab_datapath_tb
`default_nettype wire
